/* File: core/hcsp_port.sv */
// Host configuration serial port, SPI slave, I2C slave or pin mode chosen by strap
`timescale 1ns/100ps
`default_nettype none
`include "hcsp_cfg.svh"

module hcsp_port (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_mode_strap,
    input wire logic i_mode_strap_open,
    input wire logic i_host_clk,
    input wire logic i_spi_select_n,
    input wire logic i_sda_mosi,
    output logic o_sda_out,
    output logic o_sda_oe,
    output logic o_spi_serial_out,
    output logic o_spi_serial_out_oe,
    output logic [1:0] o_host_mode,
    output logic [`HCSP_ADDR_W-1:0] o_reg_addr,
    output logic [`HCSP_WORD_W-1:0] o_reg_wdata,
    output logic [1:0] o_reg_be,
    output logic o_reg_we,
    input wire logic [`HCSP_WORD_W-1:0] i_reg_rdata
);
    hcsp_pkg::hcsp_state_s r;
    hcsp_pkg::hcsp_state_s nxt;
    logic [4:0] lvl;
    logic [4:0] rise;
    logic [4:0] fall;
    logic clk_lvl;
    logic clk_rise;
    logic clk_fall;
    logic sel_lvl;
    logic sda_lvl;
    logic i2c_start;
    logic i2c_stop;
    logic [`HCSP_WORD_W-1:0] hdr;
    logic [7:0] ibyte;
    logic [7:0] tx_byte;

    // Next byte position: block walks high then low then next register
    function automatic logic [`HCSP_ADDR_W:0] adv(input logic [`HCSP_ADDR_W-1:0] a, input logic bsel,
                                                 input logic blk);
        if (!blk) begin
            adv = {a, bsel};
        end else if (bsel) begin
            adv = {a + 11'h1, 1'b0};
        end else begin
            adv = {a, 1'b1};
        end
    endfunction

    // Selected byte of a register, high byte first
    function automatic logic [7:0] byte_of(input logic [`HCSP_WORD_W-1:0] d, input logic bsel);
        byte_of = bsel ? d[7:0] : d[15:8];
    endfunction

    hcsp_sync #(.W(5)) u_sync (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_pin({i_mode_strap_open, i_mode_strap, i_sda_mosi, i_spi_select_n, i_host_clk}),
        .o_level(lvl),
        .o_rise(rise),
        .o_fall(fall)
    );

    // Synchronised pin views and decoded frame symbols
    assign clk_lvl = lvl[0];
    assign clk_rise = rise[0];
    assign clk_fall = fall[0];
    assign sel_lvl = lvl[1];
    assign sda_lvl = lvl[2];
    assign i2c_start = fall[2] && clk_lvl && !clk_rise && !r.sda_oe;
    assign i2c_stop = rise[2] && clk_lvl && !clk_rise && !r.sda_oe;
    assign hdr = {r.sin[14:0], sda_lvl};
    assign ibyte = {r.ish[6:0], sda_lvl};
    assign tx_byte = byte_of(i_reg_rdata, r.ibsel); // Byte due next on a read

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        nxt = r;
        nxt.we = 1'b0;
        // Strap caught once, a few cycles after reset release
        if (!r.strap_done) begin
            nxt.strap_cnt = r.strap_cnt + 2'h1;
            if (r.strap_cnt == `HCSP_STRAP_WAIT) begin
                nxt.strap_done = 1'b1;
                nxt.mode = lvl[4] ? hcsp_pkg::HCSP_PINS : (lvl[3] ? hcsp_pkg::HCSP_I2C : hcsp_pkg::HCSP_SPI);
            end
        end
        // SPI slave
        if (r.mode != hcsp_pkg::HCSP_SPI || sel_lvl) begin
            nxt.sst = hcsp_pkg::S_IDLE;
            nxt.spi_oe = 1'b0;
        end else begin
            case (r.sst)
                hcsp_pkg::S_IDLE: begin
                    nxt.sst = hcsp_pkg::S_HDR;
                    nxt.scnt = 4'h0;
                end
                hcsp_pkg::S_HDR: begin
                    if (clk_rise) begin
                        nxt.sin = hdr;
                        nxt.scnt = r.scnt + 4'h1;
                        if (r.scnt == `HCSP_SPI_LAST) begin
                            nxt.srd = hdr[`HCSP_SPI_RD_BIT];
                            nxt.addr = hdr[`HCSP_ADDR_W-1:0];
                            if (hdr[`HCSP_SPI_FIX_HI:`HCSP_SPI_FIX_LO] != `HCSP_SPI_FIXED) begin
                                nxt.sst = hcsp_pkg::S_SKIP;
                            end else begin
                                nxt.sst = hdr[`HCSP_SPI_RD_BIT] ? hcsp_pkg::S_LOAD : hcsp_pkg::S_DATA;
                            end
                        end
                    end
                end
                hcsp_pkg::S_LOAD: begin
                    nxt.sout = i_reg_rdata;
                    nxt.spi_out = i_reg_rdata[`HCSP_WORD_W-1];
                    nxt.spi_oe = 1'b1;
                    nxt.sst = hcsp_pkg::S_DATA;
                end
                hcsp_pkg::S_DATA: begin
                    if (clk_rise) begin
                        nxt.sin = hdr;
                        nxt.scnt = r.scnt + 4'h1;
                        nxt.sout = {r.sout[14:0], 1'b0};
                        nxt.spi_out = r.sout[14];
                        if (r.scnt == `HCSP_SPI_LAST) begin
                            nxt.sst = hcsp_pkg::S_INC;
                            if (!r.srd) begin
                                nxt.we = 1'b1;
                                nxt.wdata = hdr;
                                nxt.be = `HCSP_BE_BOTH;
                            end
                        end
                    end
                end
                hcsp_pkg::S_INC: begin
                    nxt.addr = r.addr + 11'h1;
                    nxt.sst = r.srd ? hcsp_pkg::S_LOAD : hcsp_pkg::S_DATA;
                end
                hcsp_pkg::S_SKIP: begin
                    nxt.sst = hcsp_pkg::S_SKIP;
                end
                default: begin
                    nxt.sst = hcsp_pkg::S_IDLE;
                end
            endcase
        end
        // I2C slave
        if (r.mode != hcsp_pkg::HCSP_I2C || i2c_stop) begin
            nxt.ist = hcsp_pkg::I_IDLE;
            nxt.sda_oe = 1'b0;
        end else if (i2c_start) begin
            nxt.ist = hcsp_pkg::I_RX;
            nxt.iph = 2'h0;
            nxt.ibc = 4'h0;
            nxt.sda_oe = 1'b0;
        end else begin
            case (r.ist)
                hcsp_pkg::I_RX: begin
                    if (clk_rise) begin
                        nxt.ish = ibyte;
                        nxt.ibc = r.ibc + 4'h1;
                        if (r.ibc == `HCSP_I2C_LAST) begin
                            nxt.ist = hcsp_pkg::I_WAIT;
                            nxt.iack = 1'b0;
                            case (r.iph)
                                2'h0: begin
                                    if (ibyte[7:1] == `HCSP_I2C_ADDR && !sel_lvl) begin
                                        nxt.ist = hcsp_pkg::I_ACK;
                                        nxt.irw = ibyte[0];
                                    end
                                end
                                2'h1: begin
                                    if (ibyte[6:4] == `HCSP_I2C_ZERO) begin
                                        nxt.ist = hcsp_pkg::I_ACK;
                                        nxt.iblk = ibyte[`HCSP_I2C_BLK_BIT];
                                        nxt.addr = {7'h0, ibyte[3:0]};
                                        nxt.ibsel = 1'b0;
                                    end
                                end
                                default: begin
                                    nxt.ist = hcsp_pkg::I_ACK;
                                    nxt.we = 1'b1;
                                    nxt.wdata = {ibyte, ibyte};
                                    nxt.be = r.ibsel ? `HCSP_BE_LOW : `HCSP_BE_HIGH;
                                end
                            endcase
                        end
                    end
                end
                hcsp_pkg::I_ACK: begin
                    if (clk_fall && !r.iack) begin
                        nxt.iack = 1'b1;
                        nxt.sda_oe = 1'b1;
                    end else if (clk_fall) begin
                        nxt.iack = 1'b0;
                        nxt.sda_oe = 1'b0;
                        nxt.ibc = 4'h0;
                        nxt.ist = hcsp_pkg::I_RX;
                        nxt.iph = (r.iph == 2'h0 && !r.irw) ? 2'h1 : 2'h2;
                        if (r.iph == 2'h2) begin
                            {nxt.addr, nxt.ibsel} = adv(r.addr, r.ibsel, r.iblk);
                        end
                        if (r.irw) begin
                            nxt.itx = tx_byte;
                            nxt.sda_oe = ~tx_byte[7];
                            nxt.ist = hcsp_pkg::I_TX;
                        end
                    end
                end
                hcsp_pkg::I_TX: begin
                    if (clk_rise) begin
                        nxt.ibc = r.ibc + 4'h1;
                    end else if (clk_fall && r.ibc == `HCSP_I2C_BITS) begin
                        nxt.sda_oe = 1'b0;
                        nxt.ist = hcsp_pkg::I_TXACK;
                    end else if (clk_fall) begin
                        nxt.itx = {r.itx[6:0], 1'b0};
                        nxt.sda_oe = ~r.itx[6];
                    end
                end
                hcsp_pkg::I_TXACK: begin
                    if (clk_rise && sda_lvl) begin
                        nxt.ist = hcsp_pkg::I_WAIT;
                    end else if (clk_rise) begin
                        {nxt.addr, nxt.ibsel} = adv(r.addr, r.ibsel, r.iblk);
                        nxt.ist = hcsp_pkg::I_TXLD;
                    end
                end
                hcsp_pkg::I_TXLD: begin
                    if (clk_fall) begin
                        nxt.itx = tx_byte;
                        nxt.sda_oe = ~tx_byte[7];
                        nxt.ibc = 4'h0;
                        nxt.ist = hcsp_pkg::I_TX;
                    end
                end
                hcsp_pkg::I_IDLE, hcsp_pkg::I_WAIT: begin
                    nxt.sda_oe = 1'b0;
                end
                default: begin
                    nxt.ist = hcsp_pkg::I_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    // Outputs from flip-flops, except the SDA data output, which is tied low
    assign o_sda_out = 1'b0;
    assign o_sda_oe = r.sda_oe;
    assign o_spi_serial_out = r.spi_out;
    assign o_spi_serial_out_oe = r.spi_oe;
    assign o_host_mode = r.mode;
    assign o_reg_addr = r.addr;
    assign o_reg_wdata = r.wdata;
    assign o_reg_be = r.be;
    assign o_reg_we = r.we;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_hdr_last;
        r.mode == hcsp_pkg::HCSP_SPI && !sel_lvl && r.sst == hcsp_pkg::S_HDR && clk_rise && r.scnt == 4'hf;
    endsequence

    sequence s_i2c_byte0;
        r.mode == hcsp_pkg::HCSP_I2C && r.ist == hcsp_pkg::I_RX && !i2c_start && !i2c_stop && clk_rise
            && r.ibc == 4'h7 && r.iph == 2'h0;
    endsequence

    a_spi_abort_nowr: assert property ($rose(sel_lvl) |=> !o_reg_we [*2]) else $error("write after abort");
    a_spi_fixed_skip: assert property (s_hdr_last ##0 hdr[14:11] != 4'h1 |=> r.sst == hcsp_pkg::S_SKIP)
        else $error("bad fixed field accepted");
    a_spi_read_dir: assert property (s_hdr_last ##0 hdr[14:11] == 4'h1 && hdr[15] |=> r.sst == hcsp_pkg::S_LOAD
        ##1 o_spi_serial_out_oe && o_spi_serial_out == $past(i_reg_rdata[15])) else $error("read not started");
    a_spi_addr_inc: assert property (r.sst == hcsp_pkg::S_INC && !sel_lvl |=> o_reg_addr == $past(o_reg_addr) + 11'h1)
        else $error("pointer not advanced");
    a_spi_write_hdr: assert property (o_reg_we && o_host_mode == hcsp_pkg::HCSP_SPI |-> o_reg_be == 2'h3 && !r.srd)
        else $error("bad spi write");
    a_i2c_start_rx: assert property (r.mode == hcsp_pkg::HCSP_I2C && i2c_start && !i2c_stop
        |=> r.ist == hcsp_pkg::I_RX && r.ibc == 4'h0 && !o_sda_oe) else $error("start not taken");
    a_i2c_addr_nack: assert property (s_i2c_byte0 ##0 ibyte[7:1] != 7'h28 |=> r.ist == hcsp_pkg::I_WAIT [*2])
        else $error("foreign address acknowledged");
    a_i2c_ack_drive: assert property (r.ist == hcsp_pkg::I_ACK && r.iack |-> o_sda_oe)
        else $error("ack slot not driven");
    a_sda_hold_high: assert property (clk_lvl && $past(clk_lvl) && !clk_fall |-> $stable(o_sda_oe))
        else $error("data changed with clock high");
    a_strap_frozen: assert property (r.strap_done |=> $stable(o_host_mode)) else $error("mode changed");
endmodule

`default_nettype wire

/* File: core/hcsp_cfg.svh */
// Constants of the host configuration serial port
`ifndef HCSP_CFG_SVH
`define HCSP_CFG_SVH

`define HCSP_WORD_W 16
`define HCSP_ADDR_W 11
`define HCSP_SPI_RD_BIT 15
`define HCSP_SPI_FIX_HI 14
`define HCSP_SPI_FIX_LO 11
`define HCSP_SPI_FIXED 4'h1
`define HCSP_SPI_LAST 4'hf
`define HCSP_I2C_ADDR 7'h28
`define HCSP_I2C_BLK_BIT 7
`define HCSP_I2C_ZERO 3'h0
`define HCSP_I2C_LAST 4'h7
`define HCSP_I2C_BITS 4'h8
`define HCSP_STRAP_WAIT 2'h3
`define HCSP_BE_BOTH 2'h3
`define HCSP_BE_HIGH 2'h2
`define HCSP_BE_LOW 2'h1

`endif

/* File: core/hcsp_pkg.sv */
// Types of the host configuration serial port
`include "hcsp_cfg.svh"

package hcsp_pkg;

    typedef enum logic [1:0] {HCSP_PINS, HCSP_SPI, HCSP_I2C} hcsp_mode_e;
    typedef enum logic [2:0] {S_IDLE, S_HDR, S_LOAD, S_DATA, S_INC, S_SKIP} hcsp_spi_e;
    typedef enum logic [2:0] {I_IDLE, I_RX, I_ACK, I_TX, I_TXACK, I_TXLD, I_WAIT} hcsp_i2c_e;

    typedef struct packed {
        hcsp_mode_e mode;
        logic [1:0] strap_cnt;
        logic strap_done;
        hcsp_spi_e sst;
        logic [3:0] scnt;
        logic [`HCSP_WORD_W-1:0] sin;
        logic [`HCSP_WORD_W-1:0] sout;
        logic srd;
        logic spi_out;
        logic spi_oe;
        hcsp_i2c_e ist;
        logic [3:0] ibc;
        logic [7:0] ish;
        logic [1:0] iph;
        logic irw;
        logic iblk;
        logic ibsel;
        logic iack;
        logic [7:0] itx;
        logic sda_oe;
        logic [`HCSP_ADDR_W-1:0] addr;
        logic [`HCSP_WORD_W-1:0] wdata;
        logic we;
        logic [1:0] be;
    } hcsp_state_s;

endpackage

/* File: core/hcsp_sync.sv */
// Three-stage pin synchroniser with level and edge outputs
`timescale 1ns/100ps
`default_nettype none

module hcsp_sync #(
    parameter int W = 1
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic [W-1:0] i_pin,
    output logic [W-1:0] o_level,
    output logic [W-1:0] o_rise,
    output logic [W-1:0] o_fall
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
        logic [W-1:0] rise;
        logic [W-1:0] fall;
    } hcsp_sync_s;

    hcsp_sync_s r;
    hcsp_sync_s nxt;

    // Accept a change once stages two and three agree
    always_comb begin
        nxt = r;
        nxt.s1 = i_pin;
        nxt.s2 = r.s1;
        nxt.s3 = r.s2;
        // Compare the values being loaded into stages two and three, so a strap
        // read four edges after reset already sees the real pin level
        for (int i = 0; i < W; i++) begin
            nxt.lvl[i] = (nxt.s2[i] == nxt.s3[i]) ? nxt.s3[i] : r.lvl[i];
        end
        nxt.rise = nxt.lvl & ~r.lvl;
        nxt.fall = ~nxt.lvl & r.lvl;
    end

    // State register, idle lines read high
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            r <= '{s1: '1, s2: '1, s3: '1, lvl: '1, rise: '0, fall: '0};
        end else begin
            r <= nxt;
        end
    end

    assign o_level = r.lvl;
    assign o_rise = r.rise;
    assign o_fall = r.fall;
endmodule

`default_nettype wire

/* File: tb/hcsp_host.sv */
// Host master model driving the SPI or I2C pins of the port
`timescale 1ns/100ps
`default_nettype none

module hcsp_host (
    input wire logic i_sda_oe,
    input wire logic i_spi_serial_out,
    output logic o_host_clk,
    output logic o_spi_select_n,
    output logic o_line
);
    logic clk_r = 1'b0;
    logic sel_r = 1'b1;
    logic sda_r = 1'b1;

    // Pulled-up data wire; the port can only pull it low
    assign o_line = sda_r & ~i_sda_oe;
    assign o_host_clk = clk_r;
    assign o_spi_select_n = sel_r;

    // Idle levels; in I2C mode select doubles as the address pin, held low
    task automatic set_idle(input logic i2c);
        clk_r <= i2c;
        sel_r <= ~i2c;
        sda_r <= 1'b1;
    endtask

    // Sole slave; 125 ns clock, stands still while select is high
    task automatic spi_xfer(input logic [47:0] tx, input int n, output logic [47:0] rx);
        rx = 48'h0;
        sel_r <= 1'b0;
        for (int i = 0; i < n; i++) begin
            #31.0 sda_r <= tx[47-i];
            #31.5 rx[47-i] = i_spi_serial_out;
            clk_r <= 1'b1;
            #62.5 clk_r <= 1'b0;
        end
        #62.5 sel_r <= 1'b1;
        sda_r <= ~sda_r;
        #250;
    endtask

    // Start or repeated start from clock low or idle
    task automatic i2c_start();
        #31.0 sda_r <= 1'b1;
        #31.5 clk_r <= 1'b1;
        #62.5 sda_r <= 1'b0;
        #62.5 clk_r <= 1'b0;
    endtask

    // Stop, then bus free time
    task automatic i2c_stop();
        #31.0 sda_r <= 1'b0;
        #31.5 clk_r <= 1'b1;
        #62.5 sda_r <= 1'b1;
        #250;
    endtask

    // Eight bits MSB first and the ack slot; ak is the host's own ack level
    task automatic i2c_byte(input logic [7:0] tx, input logic ak, output logic [7:0] rx, output logic ack);
        for (int i = 0; i < 9; i++) begin
            #31.0 sda_r <= (i < 8) ? tx[7-i] : ak;
            #31.5 clk_r <= 1'b1;
            #62.5 ack = o_line;
            if (i < 8) begin
                rx[7-i] = o_line;
            end
            clk_r <= 1'b0;
        end
    endtask
endmodule

`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench of the host configuration serial port
`timescale 1ns/100ps
`default_nettype none
`include "hcsp_cfg.svh"

module testbench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic strap = 1'b0;
    logic strap_open = 1'b0;
    wire host_clk, sel_n, line, sda_oe, sda_out, miso, miso_oe, we;
    wire [1:0] mode, be;
    wire [`HCSP_ADDR_W-1:0] addr;
    wire [`HCSP_WORD_W-1:0] wdata;
    logic [15:0] mem [16];
    logic [15:0] rdata;
    int n_fail = 0;
    int check_count = 0;

    // Core clock, 8 ns
    always #4 clk = ~clk;

    hcsp_port u_dut (.i_core_clk(clk), .i_rstn(rstn), .i_mode_strap(strap),
        .i_mode_strap_open(strap_open), .i_host_clk(host_clk), .i_spi_select_n(sel_n),
        .i_sda_mosi(line), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_spi_serial_out(miso),
        .o_spi_serial_out_oe(miso_oe), .o_host_mode(mode), .o_reg_addr(addr),
        .o_reg_wdata(wdata), .o_reg_be(be), .o_reg_we(we), .i_reg_rdata(rdata));

    hcsp_host u_host (.i_sda_oe(sda_oe), .i_spi_serial_out(miso), .o_host_clk(host_clk),
        .o_spi_select_n(sel_n), .o_line(line));

    // Register file: combinational read, byte-enabled write
    assign rdata = mem[addr[3:0]];
    always @(posedge clk) begin
        if (we && be[1]) begin
            mem[addr[3:0]][15:8] <= wdata[15:8];
        end
        if (we && be[0]) begin
            mem[addr[3:0]][7:0] <= wdata[7:0];
        end
    end

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Reset with a given strap, then check the chosen mode
    task automatic do_reset(input logic s, input logic o);
        @(posedge clk);
        rstn <= 1'b0;
        strap <= s;
        strap_open <= o;
        u_host.set_idle(s & ~o);
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (12) @(posedge clk);
        chk("mode", {14'h0, (o ? 2'h0 : (s ? 2'h2 : 2'h1))}, {14'h0, mode});
    endtask

    // Block write of two words, then block read of them back
    task automatic t_spi_block();
        logic [47:0] rx;
        u_host.spi_xfer({1'b0, 4'h1, 11'h002, 16'ha5c3, 16'h3c5a}, 48, rx);
        chk("mem2", 16'ha5c3, mem[2]);
        chk("mem3", 16'h3c5a, mem[3]);
        u_host.spi_xfer({1'b1, 4'h1, 11'h002, 32'h0}, 48, rx);
        chk("rd2", 16'ha5c3, rx[31:16]);
        chk("rd3", 16'h3c5a, rx[15:0]);
        chk("miso_oe", 16'h0, {15'h0, miso_oe});
    endtask

    // Foreign fixed field, a frame one bit short, then a good frame
    task automatic t_spi_refuse();
        logic [47:0] rx;
        u_host.spi_xfer({1'b0, 4'h3, 11'h005, 16'hffff, 16'h0}, 32, rx);
        chk("mem5", 16'h5555, mem[5]);
        u_host.spi_xfer({1'b0, 4'h1, 11'h006, 16'hffff, 16'h0}, 31, rx);
        chk("mem6", 16'h6666, mem[6]);
        u_host.spi_xfer({1'b0, 4'h1, 11'h006, 16'h1234, 16'h0}, 32, rx);
        chk("mem6b", 16'h1234, mem[6]);
    endtask

    // One byte sent by the host and its acknowledge judged
    task automatic wr(input logic [7:0] b, input logic ak, input string name);
        logic [7:0] rx;
        logic ack;
        u_host.i2c_byte(b, 1'b1, rx, ack);
        chk(name, {15'h0, ak}, {15'h0, ack});
    endtask

    task automatic t_i2c_write();
        u_host.i2c_start();
        wr(8'h50, 1'b0, "ack_addr");
        wr(8'h84, 1'b0, "ack_reg");
        wr(8'hbe, 1'b0, "ack_hi");
        wr(8'hef, 1'b0, "ack_lo");
        u_host.i2c_stop();
        chk("mem4", 16'hbeef, mem[4]);
        chk("sda_oe", 16'h0, {15'h0, sda_oe});
        chk("sda_out", 16'h0, {15'h0, sda_out});
    endtask

    task automatic t_i2c_read();
        logic [7:0] hi;
        logic [7:0] lo;
        logic ack;
        u_host.i2c_start();
        wr(8'h50, 1'b0, "ack_a");
        wr(8'h84, 1'b0, "ack_r");
        u_host.i2c_start();
        wr(8'h51, 1'b0, "ack_ar");
        u_host.i2c_byte(8'hff, 1'b0, hi, ack);
        u_host.i2c_byte(8'hff, 1'b1, lo, ack);
        u_host.i2c_stop();
        chk("rd4", 16'hbeef, {hi, lo});
    endtask

    // Wrong bus address, bad register byte, then a single-byte write
    task automatic t_i2c_refuse();
        u_host.i2c_start();
        wr(8'h52, 1'b1, "nak_addr");
        u_host.i2c_stop();
        u_host.i2c_start();
        wr(8'h50, 1'b0, "ack_b");
        wr(8'hb4, 1'b1, "nak_reg");
        u_host.i2c_stop();
        u_host.i2c_start();
        wr(8'h50, 1'b0, "ack_c");
        wr(8'h05, 1'b0, "ack_byte");
        wr(8'h77, 1'b0, "ack_d");
        u_host.i2c_stop();
        chk("mem5b", 16'h7755, mem[5]);
    endtask

    // Main sequence: SPI, I2C, then pin mode
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = {4{i[3:0]}};
        end
        do_reset(1'b0, 1'b0);
        t_spi_block();
        t_spi_refuse();
        do_reset(1'b1, 1'b0);
        t_i2c_write();
        t_i2c_read();
        t_i2c_refuse();
        do_reset(1'b0, 1'b1);
        final_report();
    end

    // Watchdog, well beyond the expected run
    initial begin
        #200000;
        n_fail++;
        final_report();
    end
endmodule

`default_nettype wire
